// [core/bscr_pkg.sv]
// Purpose: constants and carrier types of the board special control block
// Assumes: 100 MHz ref_clk_in, 10-bit I/O addresses, byte-wide data
// Notes:   all offsets, bit positions and timing counts live here
////////////////////////////////////////////////////////////////////////////////
package bscr_pkg;
  // i/o decode
  localparam logic [9:0] BSCR_BASE_STD   = 10'h0e0;
  localparam logic [9:0] BSCR_BASE_ALT   = 10'h1e0;
  localparam logic [9:0] BSCR_OFS_CTRL   = 10'h000;
  localparam logic [9:0] BSCR_OFS_REFR   = 10'h001;
  localparam logic [7:0] BSCR_REFR_KEY   = 8'h5a;
  localparam logic [7:0] BSCR_RST_CTRL   = 8'h00;
  localparam logic [7:0] BSCR_RST_RDATA  = 8'h00;

  // special_control bit positions
  localparam int BSCR_B_LED      = 7;
  localparam int BSCR_B_JUMPER   = 6;
  localparam int BSCR_B_HEAT     = 5;
  localparam int BSCR_B_HEAT_NMI = 4;
  localparam int BSCR_B_THROTTLE = 3;
  localparam int BSCR_B_WD_EXP   = 2;
  localparam int BSCR_B_WD_NMI   = 1;
  localparam int BSCR_B_WD_RST   = 0;

  // watchdog timing
  localparam int unsigned BSCR_CLK_PERIOD_NS = 10;
  localparam int unsigned BSCR_WDOG_TIME_MS  = 1000;
  localparam int unsigned BSCR_NS_PER_MS     = 1000000;
  localparam int unsigned BSCR_WDOG_CYCLES   =
    (BSCR_WDOG_TIME_MS * BSCR_NS_PER_MS + BSCR_CLK_PERIOD_NS - 1)
    / BSCR_CLK_PERIOD_NS;
  localparam int BSCR_WDOG_CW = 27;
  localparam logic [BSCR_WDOG_CW-1:0] BSCR_WDOG_ZERO = 27'h0000000;
  localparam logic [BSCR_WDOG_CW-1:0] BSCR_WDOG_ONE  = 27'h0000001;

  // host i/o request
  typedef struct packed {
    logic       wr;
    logic       rd;
    logic [9:0] addr;
    logic [7:0] wdata;
  } bscr_io_req_type;

  // answer to the host
  typedef struct packed {
    logic       ack;
    logic [7:0] rdata;
  } bscr_io_rsp_type;

  // setup choices
  typedef struct packed {
    logic alt_base;
    logic ports_en;
  } bscr_setup_type;

  // board-level controls
  typedef struct packed {
    logic led;
    logic throttle;
    logic heat_nmi;
    logic wdog_nmi;
    logic wdog_reset;
  } bscr_ctl_type;

  // watchdog states
  typedef enum logic [2:0] {
    BSCR_WD_IDLE  = 3'b001,
    BSCR_WD_COUNT = 3'b010,
    BSCR_WD_FIRED = 3'b100
  } bscr_wd_state_type;
endpackage

// [core/bscr_sync.sv]
// Purpose: two-flop synchroniser for pins from outside the clock domain
// Assumes: inputs are slow levels
// Notes:   first stage is read only by the second
////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
`default_nettype none
module bscr_sync #(
  parameter int W = 1
) (
  input  wire logic         ref_clk_in,
  input  wire logic         rstn_in,
  input  wire logic [W-1:0] d_in,
  output logic      [W-1:0] q_out
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } bscr_sync_state_type;

  bscr_sync_state_type st;
  bscr_sync_state_type next_st;

  // shift through two stages
  always_comb begin
    next_st    = st;
    next_st.s1 = d_in;
    next_st.s2 = st.s1;
  end

  // registered stages
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign q_out = st.s2;
endmodule // bscr_sync
`default_nettype wire

// [core/bscr_wdog.sv]
// Purpose: watchdog timeout counter with sticky expiry
// Assumes: refresh_in is a one-cycle pulse on the same clock
// Notes:   expiry stays until a refresh; period is TIMEOUT_CYC cycles
////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
`default_nettype none
module bscr_wdog #(
  parameter int unsigned TIMEOUT_CYC = bscr_pkg::BSCR_WDOG_CYCLES
) (
  input  wire logic ref_clk_in,
  input  wire logic rstn_in,
  input  wire logic run_in,
  input  wire logic refresh_in,
  output logic      expired_out,
  output logic      fire_out
);
  localparam int              CW   = bscr_pkg::BSCR_WDOG_CW;
  localparam logic [CW-1:0]   LAST = CW'(TIMEOUT_CYC - 1);

  typedef struct packed {
    bscr_pkg::bscr_wd_state_type       fsm;
    logic [bscr_pkg::BSCR_WDOG_CW-1:0] cnt;
    logic                              expired;
    logic                              fire;
  } bscr_wd_type;

  bscr_wd_type st;
  bscr_wd_type next_st;

  // count while enabled, restart on refresh
  always_comb begin
    next_st      = st;
    next_st.fire = 1'b0;
    if (refresh_in) begin
      next_st.expired = 1'b0;
    end
    unique case (st.fsm)
      bscr_pkg::BSCR_WD_IDLE: begin
        next_st.cnt = bscr_pkg::BSCR_WDOG_ZERO;
        if (run_in) begin
          next_st.fsm = bscr_pkg::BSCR_WD_COUNT;
        end
      end
      bscr_pkg::BSCR_WD_COUNT: begin
        if (!run_in) begin
          next_st.fsm = bscr_pkg::BSCR_WD_IDLE;
        end else if (refresh_in) begin
          next_st.cnt = bscr_pkg::BSCR_WDOG_ZERO;
        end else if (st.cnt == LAST) begin
          next_st.fsm     = bscr_pkg::BSCR_WD_FIRED;
          next_st.expired = 1'b1;
          next_st.fire    = 1'b1;
        end else begin
          next_st.cnt = st.cnt + bscr_pkg::BSCR_WDOG_ONE;
        end
      end
      bscr_pkg::BSCR_WD_FIRED: begin
        next_st.cnt = bscr_pkg::BSCR_WDOG_ZERO;
        if (!run_in) begin
          next_st.fsm = bscr_pkg::BSCR_WD_IDLE;
        end else if (refresh_in) begin
          next_st.fsm = bscr_pkg::BSCR_WD_COUNT;
        end
      end
      default: begin
        next_st.fsm = bscr_pkg::BSCR_WD_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      st <= '{fsm: bscr_pkg::BSCR_WD_IDLE, default: '0};
    end else begin
      st <= next_st;
    end
  end

  assign expired_out = st.expired;
  assign fire_out    = st.fire;

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);

  property p_wd_restart;
    run_in && refresh_in && st.fsm == bscr_pkg::BSCR_WD_COUNT
      |=> st.cnt == bscr_pkg::BSCR_WDOG_ZERO && !st.fire;
  endproperty
  a_wd_restart: assert property (p_wd_restart)
    else $error("refresh did not restart watchdog");

  property p_wd_min_period;
    $rose(st.fire) |-> $past(st.cnt) == LAST;
  endproperty
  a_wd_min_period: assert property (p_wd_min_period)
    else $error("watchdog fired before full period");
endmodule // bscr_wdog
`default_nettype wire

// [core/bscr_top.sv]
// Purpose: special control register and watchdog refresh port, I/O mapped
// Assumes: host strobes are one-cycle pulses on ref_clk_in; setup inputs
//          come from logic on the same clock; pins are asynchronous
// Notes:   answers are registered one cycle after the strobe
////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
`default_nettype none
module bscr_top #(
  parameter int unsigned WDOG_TIMEOUT_CYC = bscr_pkg::BSCR_WDOG_CYCLES
) (
  input  wire logic                     ref_clk_in,
  input  wire logic                     rstn_in,
  input  wire bscr_pkg::bscr_io_req_type io_req_in,
  input  wire bscr_pkg::bscr_setup_type  setup_in,
  input  wire logic                     jumper_pin_in,
  input  wire logic                     heat_pin_in,
  input  wire logic                     force_thr_pin_in,
  output bscr_pkg::bscr_io_rsp_type     io_rsp_out,
  output bscr_pkg::bscr_ctl_type        ctl_out
);

  //////////////////////////////////////////////////////////////////////////////
  // synchronised pins

  logic [2:0] pins_raw;
  logic [2:0] pins_sync;
  logic       jumper_input_status;
  logic       cpu_heat_flag;
  logic       forced_thr;

  assign pins_raw = {force_thr_pin_in, heat_pin_in, jumper_pin_in};

  // pins pass two flops before use
  bscr_sync #(
    .W (3)
  ) u_pin_sync (
    .ref_clk_in (ref_clk_in),
    .rstn_in    (rstn_in),
    .d_in       (pins_raw),
    .q_out      (pins_sync)
  );

  assign jumper_input_status = pins_sync[0];
  assign cpu_heat_flag       = pins_sync[1];
  assign forced_thr          = pins_sync[2];

  //////////////////////////////////////////////////////////////////////////////
  // state

  typedef struct packed {
    logic                      heat_nmi_enable;
    logic                      watchdog_nmi_enable;
    logic                      watchdog_reset_enable;
    bscr_pkg::bscr_io_rsp_type rsp;
    bscr_pkg::bscr_ctl_type    ctl;
  } bscr_state_type;

  bscr_state_type st;
  bscr_state_type next_st;

  //////////////////////////////////////////////////////////////////////////////
  // address decode

  logic [9:0] base;
  logic       hit_ctrl;
  logic       hit_refr;
  logic       wr_ctrl;
  logic       rd_ctrl;
  logic       refresh;
  logic       wd_run;
  logic       wd_expired;
  logic       wd_fire;
  logic [7:0] special_control;

  // base follows the setup choice, ports vanish when disabled
  always_comb begin
    base = setup_in.alt_base ? bscr_pkg::BSCR_BASE_ALT
                             : bscr_pkg::BSCR_BASE_STD;
    hit_ctrl = setup_in.ports_en &&
               io_req_in.addr == base + bscr_pkg::BSCR_OFS_CTRL;
    hit_refr = setup_in.ports_en &&
               io_req_in.addr == base + bscr_pkg::BSCR_OFS_REFR;
    wr_ctrl  = hit_ctrl && io_req_in.wr;
    rd_ctrl  = hit_ctrl && io_req_in.rd;
    refresh  = hit_refr && io_req_in.wr &&
               io_req_in.wdata == bscr_pkg::BSCR_REFR_KEY;
  end

  //////////////////////////////////////////////////////////////////////////////
  // watchdog

  // runs while either response is armed
  assign wd_run = st.watchdog_reset_enable || st.watchdog_nmi_enable;

  bscr_wdog #(
    .TIMEOUT_CYC (WDOG_TIMEOUT_CYC)
  ) u_wdog (
    .ref_clk_in  (ref_clk_in),
    .rstn_in     (rstn_in),
    .run_in      (wd_run),
    .refresh_in  (refresh),
    .expired_out (wd_expired),
    .fire_out    (wd_fire)
  );

  //////////////////////////////////////////////////////////////////////////////
  // read image

  // live status bits beside stored controls
  always_comb begin
    special_control                            = bscr_pkg::BSCR_RST_CTRL;
    special_control[bscr_pkg::BSCR_B_LED]      = st.ctl.led;
    special_control[bscr_pkg::BSCR_B_JUMPER]   = jumper_input_status;
    special_control[bscr_pkg::BSCR_B_HEAT]     = cpu_heat_flag;
    special_control[bscr_pkg::BSCR_B_HEAT_NMI] = st.heat_nmi_enable;
    special_control[bscr_pkg::BSCR_B_THROTTLE] = st.ctl.throttle;
    special_control[bscr_pkg::BSCR_B_WD_EXP]   = wd_expired;
    special_control[bscr_pkg::BSCR_B_WD_NMI]   = st.watchdog_nmi_enable;
    special_control[bscr_pkg::BSCR_B_WD_RST]   = st.watchdog_reset_enable;
  end

  //////////////////////////////////////////////////////////////////////////////
  // next state

  always_comb begin
    next_st           = st;
    next_st.rsp.ack   = hit_ctrl && (io_req_in.rd || io_req_in.wr) ||
                        hit_refr && io_req_in.wr;
    next_st.rsp.rdata = bscr_pkg::BSCR_RST_RDATA;
    if (rd_ctrl) begin
      next_st.rsp.rdata = special_control;
    end
    // writable bits; status bits ignore writes
    if (wr_ctrl) begin
      next_st.ctl.led =
        io_req_in.wdata[bscr_pkg::BSCR_B_LED];
      next_st.heat_nmi_enable =
        io_req_in.wdata[bscr_pkg::BSCR_B_HEAT_NMI];
      next_st.ctl.throttle =
        io_req_in.wdata[bscr_pkg::BSCR_B_THROTTLE];
      next_st.watchdog_nmi_enable =
        io_req_in.wdata[bscr_pkg::BSCR_B_WD_NMI];
      next_st.watchdog_reset_enable =
        io_req_in.wdata[bscr_pkg::BSCR_B_WD_RST];
    end
    if (forced_thr) begin
      next_st.ctl.throttle = 1'b1;
    end
    // nmi levels follow cause and gate
    next_st.ctl.heat_nmi =
      cpu_heat_flag && next_st.heat_nmi_enable;
    next_st.ctl.wdog_nmi =
      wd_expired && next_st.watchdog_nmi_enable;
    // one-cycle reset request on expiry
    next_st.ctl.wdog_reset =
      wd_fire && st.watchdog_reset_enable;
  end

  //////////////////////////////////////////////////////////////////////////////
  // registers

  // all controls clear on reset
  always_ff @(posedge ref_clk_in) begin
    if (!rstn_in) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign io_rsp_out = st.rsp;
  assign ctl_out    = st.ctl;

  //////////////////////////////////////////////////////////////////////////////
  // checks

  default clocking cb @(posedge ref_clk_in); endclocking
  default disable iff (!rstn_in);

  sequence s_ctrl_write;
    setup_in.ports_en && io_req_in.wr && io_req_in.addr ==
      (setup_in.alt_base ? bscr_pkg::BSCR_BASE_ALT
                         : bscr_pkg::BSCR_BASE_STD);
  endsequence

  sequence s_ctrl_read;
    setup_in.ports_en && io_req_in.rd && !io_req_in.wr &&
      io_req_in.addr == (setup_in.alt_base ? bscr_pkg::BSCR_BASE_ALT
                                           : bscr_pkg::BSCR_BASE_STD);
  endsequence

  sequence s_refr_write;
    setup_in.ports_en && io_req_in.wr && io_req_in.addr ==
      (setup_in.alt_base ? bscr_pkg::BSCR_BASE_ALT
                         : bscr_pkg::BSCR_BASE_STD) + bscr_pkg::BSCR_OFS_REFR;
  endsequence

  property p_decode;
    s_ctrl_read |=> io_rsp_out.ack;
  endproperty
  a_decode: assert property (p_decode)
    else $error("control register read not answered");

  property p_disabled;
    !setup_in.ports_en |=> !io_rsp_out.ack &&
                           io_rsp_out.rdata == bscr_pkg::BSCR_RST_RDATA;
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("answer while ports disabled");

  property p_led;
    s_ctrl_write |=>
      ctl_out.led == $past(io_req_in.wdata[bscr_pkg::BSCR_B_LED]);
  endproperty
  a_led: assert property (p_led)
    else $error("led does not follow write");

  property p_jumper;
    s_ctrl_read |=> io_rsp_out.rdata[bscr_pkg::BSCR_B_JUMPER] ==
                    $past(pins_sync[0]);
  endproperty
  a_jumper: assert property (p_jumper)
    else $error("jumper status misread");

  property p_heat;
    s_ctrl_read |=> io_rsp_out.rdata[bscr_pkg::BSCR_B_HEAT] ==
                    $past(pins_sync[1]);
  endproperty
  a_heat: assert property (p_heat)
    else $error("heat flag misread");

  property p_heat_nmi_gate;
    s_ctrl_write ##0 !io_req_in.wdata[bscr_pkg::BSCR_B_HEAT_NMI] |=>
      !ctl_out.heat_nmi;
  endproperty
  a_heat_nmi_gate: assert property (p_heat_nmi_gate)
    else $error("heat nmi while gated off");

  property p_throttle;
    s_ctrl_write ##0 !forced_thr |=>
      ctl_out.throttle == $past(io_req_in.wdata[bscr_pkg::BSCR_B_THROTTLE]);
  endproperty
  a_throttle: assert property (p_throttle)
    else $error("throttle does not follow write");

  property p_forced;
    forced_thr |=> ctl_out.throttle;
  endproperty
  a_forced: assert property (p_forced)
    else $error("forced throttle cleared");

  property p_wd_status;
    wd_fire && !refresh ##1 s_ctrl_read |=>
      io_rsp_out.rdata[bscr_pkg::BSCR_B_WD_EXP];
  endproperty
  a_wd_status: assert property (p_wd_status)
    else $error("expiry not reported");

  property p_wd_nmi;
    wd_fire && st.watchdog_nmi_enable && !wr_ctrl |=> ctl_out.wdog_nmi;
  endproperty
  a_wd_nmi: assert property (p_wd_nmi)
    else $error("watchdog nmi missing");

  property p_wd_reset;
    wd_fire |=> ctl_out.wdog_reset == $past(st.watchdog_reset_enable)
            ##1 !ctl_out.wdog_reset;
  endproperty
  a_wd_reset: assert property (p_wd_reset)
    else $error("watchdog reset pulse wrong");

  property p_reset_vals;
    $rose(rstn_in) |-> !ctl_out.led && !st.heat_nmi_enable &&
                       !st.watchdog_nmi_enable &&
                       !st.watchdog_reset_enable && !io_rsp_out.ack;
  endproperty
  a_reset_vals: assert property (p_reset_vals)
    else $error("controls not cleared by reset");

  property p_refr_ack;
    s_refr_write |=> io_rsp_out.ack;
  endproperty
  a_refr_ack: assert property (p_refr_ack)
    else $error("refresh port write not answered");

  property p_rdata_idle;
    !rd_ctrl |=> io_rsp_out.rdata == bscr_pkg::BSCR_RST_RDATA;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle)
    else $error("read data outside a control read");

  property p_heat_nmi_on;
    cpu_heat_flag && st.heat_nmi_enable && !wr_ctrl |=> ctl_out.heat_nmi;
  endproperty
  a_heat_nmi_on: assert property (p_heat_nmi_on)
    else $error("heat nmi missing");

  property p_wd_nmi_off;
    !st.watchdog_nmi_enable && !wr_ctrl |=> !ctl_out.wdog_nmi;
  endproperty
  a_wd_nmi_off: assert property (p_wd_nmi_off)
    else $error("watchdog nmi while disabled");

  property p_wd_no_reset;
    !st.watchdog_reset_enable |=> !ctl_out.wdog_reset;
  endproperty
  a_wd_no_reset: assert property (p_wd_no_reset)
    else $error("watchdog reset while disabled");
endmodule // bscr_top
`default_nettype wire

// [bench/bscr_host.sv]
// Purpose: host model issuing I/O reads and writes to the control block
// Assumes: one strobe per access, answer registered one cycle later
// Notes:   released address and data lines show the inverse of the last value
////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
`default_nettype none
module bscr_host (
  input  wire logic                      ref_clk_in,
  input  wire bscr_pkg::bscr_io_rsp_type io_rsp_in,
  output bscr_pkg::bscr_io_req_type      io_req_out
);
  // bus idle at time zero
  initial begin
    io_req_out = '0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // one access: strobe for one edge, answer taken once it has landed
  task automatic access(input logic wr, input logic rd,
                        input logic [9:0] addr, input logic [7:0] wdata,
                        output logic ack, output logic [7:0] rdata);
    @(posedge ref_clk_in);
    io_req_out <= {wr, rd, addr, wdata};
    @(posedge ref_clk_in);
    io_req_out <= {1'b0, 1'b0, ~addr, ~wdata}; // released, stale lines flip
    #1;
    ack = io_rsp_in.ack;
    rdata = io_rsp_in.rdata;
  endtask

  // refresh key, issued well inside each period
  task automatic refresh(input logic [9:0] addr, output logic ack);
    logic [7:0] unused;
    access(1'b1, 1'b0, addr, 8'h5a, ack, unused);
  endtask
endmodule // bscr_host
`default_nettype wire

// [bench/board_special_control_register_test.sv]
// Purpose: self-checking bench for the special control register block
// Assumes: watchdog period shortened to WD_CYC cycles
// Notes:   pins settle through two sync flops before any read
////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
`default_nettype none
module board_special_control_register_test;
  localparam int unsigned WD_CYC = 20;
  logic                      ref_clk_in;
  logic                      rstn_in;
  logic                      jumper_pin_in;
  logic                      heat_pin_in;
  logic                      force_thr_pin_in;
  bscr_pkg::bscr_setup_type  setup_in;
  bscr_pkg::bscr_io_req_type io_req;
  bscr_pkg::bscr_io_rsp_type io_rsp;
  bscr_pkg::bscr_ctl_type    ctl;
  int                        failures;
  int                        num_checks;
  int                        pulses = 0;
  int                        n;
  logic                      ack;
  logic [7:0]                rd;
  // addresses that must not answer a read
  logic [9:0]                u_addr [4] =
    '{10'h0e2, 10'h0df, 10'h1e0, 10'h0e1};

  bscr_top #(.WDOG_TIMEOUT_CYC(WD_CYC)) u_bscr_top (
    .ref_clk_in       (ref_clk_in),
    .rstn_in          (rstn_in),
    .io_req_in        (io_req),
    .setup_in         (setup_in),
    .jumper_pin_in    (jumper_pin_in),
    .heat_pin_in      (heat_pin_in),
    .force_thr_pin_in (force_thr_pin_in),
    .io_rsp_out       (io_rsp),
    .ctl_out          (ctl)
  );

  bscr_host u_bscr_host (
    .ref_clk_in (ref_clk_in),
    .io_rsp_in  (io_rsp),
    .io_req_out (io_req)
  );

  // 100 MHz clock
  initial begin
    ref_clk_in = 1'b0;
    forever #5 ref_clk_in = ~ref_clk_in;
  end

  // count watchdog reset pulses
  always @(posedge ref_clk_in) begin
    if (ctl.wdog_reset === 1'b1) begin
      pulses <= pulses + 1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("CHECK FAILED %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic chk1(input logic seen, input logic exp);
    check({7'h00, seen}, {7'h00, exp});
  endtask

  task automatic wait_cyc(input int c);
    repeat (c) @(posedge ref_clk_in);
    #1;
  endtask

  task automatic rd_ctl(input logic [9:0] a);
    u_bscr_host.access(1'b0, 1'b1, a, 8'h00, ack, rd);
  endtask

  task automatic wr(input logic [9:0] a, input logic [7:0] d);
    logic [7:0] unused;
    u_bscr_host.access(1'b1, 1'b0, a, d, ack, unused);
  endtask

  task automatic do_reset();
    @(posedge ref_clk_in);
    rstn_in <= 1'b0;
    repeat (20) @(posedge ref_clk_in);
    rstn_in <= 1'b1;
    wait_cyc(5);
  endtask

  task automatic complete_run();
    $display("checks %0d failures %0d", num_checks, failures);
    if (failures == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // hang guard, far beyond the planned run
  initial begin
    #50000;
    failures++;
    complete_run();
  end

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    failures = 0;
    num_checks = 0;
    rstn_in = 1'b0;
    setup_in = 2'b01;
    jumper_pin_in = 1'b0;
    heat_pin_in = 1'b0;
    force_thr_pin_in = 1'b0;
    do_reset();
    check({3'h0, ctl}, 8'h00);
    rd_ctl(10'h0e0);
    chk1(ack, 1'b1);
    check(rd, 8'h00);
    // jumper and heat pins high, every writable bit set
    @(posedge ref_clk_in);
    jumper_pin_in <= 1'b1;
    heat_pin_in <= 1'b1;
    wait_cyc(4);
    wr(10'h0e0, 8'hff);
    chk1(ack, 1'b1);
    chk1(ctl.led, 1'b1);
    chk1(ctl.throttle, 1'b1);
    wait_cyc(2);
    chk1(ctl.heat_nmi, 1'b1);
    rd_ctl(10'h0e0);
    check(rd, 8'hfb);
    // clear all: read-only bits keep their pin state
    wr(10'h0e0, 8'h00);
    chk1(ctl.led, 1'b0);
    chk1(ctl.throttle, 1'b0);
    wait_cyc(2);
    chk1(ctl.heat_nmi, 1'b0);
    rd_ctl(10'h0e0);
    check(rd, 8'h60);
    @(posedge ref_clk_in);
    heat_pin_in <= 1'b0;
    wait_cyc(4);
    rd_ctl(10'h0e0);
    check(rd, 8'h40);
    // neighbouring and alternate addresses stay silent
    foreach (u_addr[i]) begin
      rd_ctl(u_addr[i]);
      chk1(ack, 1'b0);
    end
    @(posedge ref_clk_in);
    setup_in <= 2'b11;
    rd_ctl(10'h0e0);
    chk1(ack, 1'b0);
    rd_ctl(10'h1e0);
    chk1(ack, 1'b1);
    check(rd, 8'h40);
    // ports disabled in setup
    @(posedge ref_clk_in);
    setup_in <= 2'b10;
    rd_ctl(10'h1e0);
    chk1(ack, 1'b0);
    wr(10'h1e1, 8'h5a);
    chk1(ack, 1'b0);
    @(posedge ref_clk_in);
    setup_in <= 2'b01;
    // watchdog held off by timely refreshes
    wr(10'h0e0, 8'h03);
    for (int k = 0; k < 6; k++) begin
      wait_cyc(WD_CYC / 2);
      u_bscr_host.refresh(10'h0e1, ack);
      chk1(ack, 1'b1);
    end
    rd_ctl(10'h0e0);
    chk1(rd[2], 1'b0);
    check(pulses[7:0], 8'h00);
    // odd key is answered but leaves the period running
    wr(10'h0e1, 8'ha5);
    chk1(ack, 1'b1);
    n = 0;
    while (pulses == 0 && n < 3 * WD_CYC) begin
      wait_cyc(1);
      n++;
    end
    // pulse counted two edges after expiry; key came four after refresh
    check(n[7:0], 8'(WD_CYC - 2));
    chk1(ctl.wdog_nmi, 1'b1);
    wait_cyc(3);
    check(pulses[7:0], 8'h01);
    rd_ctl(10'h0e0);
    chk1(rd[2], 1'b1);
    wr(10'h0e1, 8'ha5);
    rd_ctl(10'h0e0);
    chk1(rd[2], 1'b1);
    u_bscr_host.refresh(10'h0e1, ack);
    rd_ctl(10'h0e0);
    chk1(rd[2], 1'b0);
    chk1(ctl.wdog_nmi, 1'b0);
    // interrupt only: expiry brings no reset
    wr(10'h0e0, 8'h02);
    wait_cyc(WD_CYC + 6);
    chk1(ctl.wdog_nmi, 1'b1);
    check(pulses[7:0], 8'h01);
    // reset only: expiry brings no interrupt
    u_bscr_host.refresh(10'h0e1, ack);
    wr(10'h0e0, 8'h01);
    wait_cyc(WD_CYC + 6);
    chk1(ctl.wdog_nmi, 1'b0);
    check(pulses[7:0], 8'h02);
    wr(10'h0e0, 8'h00);
    // forced-throttle board: set out of reset, writes cannot clear
    @(posedge ref_clk_in);
    force_thr_pin_in <= 1'b1;
    do_reset();
    chk1(ctl.throttle, 1'b1);
    wr(10'h0e0, 8'h00);
    rd_ctl(10'h0e0);
    check(rd, 8'h48);
    chk1(ctl.throttle, 1'b1);
    complete_run();
  end
endmodule // board_special_control_register_test
`default_nettype wire
